/* File: rtl/dec_pkg.sv */
`default_nettype none
package dec_pkg;
    localparam int          DEC_COUNTERS       = 5;
    localparam int          DEC_LANES          = 4;
    localparam logic [4:0]  DEC_DEVAD          = 5'h1e;
    localparam logic [15:0] DEC_HS_ADDR        = 16'h0010;
    localparam logic [15:0] DEC_LN0_ADDR       = 16'h0011;
    localparam logic [15:0] DEC_LN1_ADDR       = 16'h0012;
    localparam logic [15:0] DEC_LN2_ADDR       = 16'h0013;
    localparam logic [15:0] DEC_LN3_ADDR       = 16'h0014;
    localparam logic [15:0] DEC_RESET_COUNT    = 16'hfffd;
    localparam logic [15:0] DEC_KR_RESET_COUNT = 16'h0000;
    localparam logic [15:0] DEC_CLEARED_COUNT  = 16'h0000;
    localparam logic [15:0] DEC_COUNT_MAX      = 16'hffff;
    localparam logic [5:0]  DEC_PREAMBLE_BITS  = 6'h20;
    localparam logic [3:0]  DEC_OP_LAST_BIT    = 4'h1;
    localparam logic [3:0]  DEC_ADDR_LAST_BIT  = 4'h4;
    localparam logic [3:0]  DEC_DATA_LAST_BIT  = 4'hf;
    localparam logic [1:0]  DEC_OP_ADDRESS     = 2'h0;
    localparam logic [1:0]  DEC_OP_WRITE       = 2'h1;
    localparam logic [1:0]  DEC_OP_READ_INC    = 2'h2;
    localparam logic [1:0]  DEC_OP_READ        = 2'h3;

    typedef enum logic [1:0] {
        DEC_MODE_KR     = 2'h0,
        DEC_MODE_KX     = 2'h1,
        DEC_MODE_GEN10G = 2'h2
    } dec_mode_e;

    typedef enum logic [2:0] {
        DEC_ST_PREAMBLE = 3'h0,
        DEC_ST_START    = 3'h1,
        DEC_ST_OPCODE   = 3'h3,
        DEC_ST_PORT     = 3'h2,
        DEC_ST_DEVICE   = 3'h6,
        DEC_ST_TURN     = 3'h7,
        DEC_ST_DATA     = 3'h5
    } dec_state_e;
endpackage : dec_pkg
`default_nettype wire

/* File: rtl/dec_err_counter.sv */
`default_nettype none
module dec_err_counter
    import dec_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic [15:0] reset_value_i,
    input  wire logic        count_i,
    input  wire logic        clear_i,
    output logic      [15:0] count_o
);
    logic [15:0] count_reg;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            count_reg <= reset_value_i;
        end else if (clear_i) begin
            // An error in the read cycle survives the clear
            count_reg <= count_i ? 16'h0001 : DEC_CLEARED_COUNT;
        end else if (count_i && count_reg != DEC_COUNT_MAX) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    assign count_o = count_reg;
endmodule : dec_err_counter
`default_nettype wire

/* File: rtl/dec_error_counters.sv */
`default_nettype none
// Behaviour
// - Fast counter counts decoder invalid and disparity words
// - KR read of fast counter clears FEC field
// - Fast resets zero in KR, else FFFD
// - Fast test mode counts selected pattern mismatches
// - Pseudo-random pin makes fast counter count PRBS
// - Read returns value then clears counter
// - KR/KX lane counters count lane decoder errors
// - General 10G lanes count alignment decoder errors
// - Slow test mode counts selected pattern errors
// - Counters at 0x10..0x13 in device 0x1E
// - Lane 3 counter at 0x14, same behaviour
module dec_error_counters
    import dec_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 mdc_i,
    input  wire logic                 mdio_i,
    output logic                      mdio_o,
    output logic                      mdio_oe_o,
    input  wire logic [4:0]           phy_addr_i,
    input  wire logic [1:0]           mode_i,
    input  wire logic                 hs_test_verify_i,
    input  wire logic                 ls_test_verify_i,
    input  wire logic                 pseudo_random_check_pin_i,
    input  wire logic [2:0]           hs_pattern_sel_i,
    input  wire logic [1:0]           ls_pattern_sel_i,
    input  wire logic                 hs_code_invalid_i,
    input  wire logic                 hs_disparity_err_i,
    input  wire logic                 hs_pattern_err_i,
    input  wire logic                 hs_prbs_err_i,
    input  wire logic [DEC_LANES-1:0] ls_code_invalid_i,
    input  wire logic [DEC_LANES-1:0] ls_disparity_err_i,
    input  wire logic [DEC_LANES-1:0] ls_align_code_invalid_i,
    input  wire logic [DEC_LANES-1:0] ls_pattern_err_i,
    output logic [2:0]                hs_checker_sel_o,
    output logic [1:0]                ls_checker_sel_o,
    output logic                      kr_fec_clear_o,
    output logic [15:0]               fast_side_error_tally_o,
    output logic [15:0]               slow_side_lane0_tally_o,
    output logic [15:0]               slow_side_lane1_tally_o,
    output logic [15:0]               slow_side_lane2_tally_o,
    output logic [15:0]               slow_side_lane3_tally_o
);
    dec_state_e  state_reg;
    logic        mdc_q_reg;
    logic [5:0]  ones_reg;
    logic [3:0]  bit_reg;
    logic [1:0]  op_reg;
    logic [4:0]  port_reg;
    logic [4:0]  dev_reg;
    logic [15:0] in_reg;
    logic [15:0] out_reg;
    logic [15:0] addr_reg;
    logic        match_reg;
    logic        mdio_reg;
    logic        oe_reg;
    logic        kr_clear_reg;
    logic [2:0]  hs_sel_reg;
    logic [1:0]  ls_sel_reg;

    logic        mdc_rise;
    logic        match_now;
    logic        read_go;
    logic        op_is_read;
    logic        addr_hit;
    logic [15:0] addr_index;
    logic [15:0] rd_data;
    logic        kr_mode;
    logic [15:0] count_w [DEC_COUNTERS];
    logic [DEC_COUNTERS-1:0] event_w;
    logic [DEC_COUNTERS-1:0] clear_w;

    // MDC is slow against clk_i, so its rise is found by edge detection
    assign mdc_rise   = mdc_i & ~mdc_q_reg;
    assign kr_mode    = (mode_i == DEC_MODE_KR);
    assign match_now  = (port_reg == phy_addr_i) && ({dev_reg[3:0], mdio_i} == DEC_DEVAD);
    // Both read opcodes share the latch, turnaround and data drive
    assign op_is_read = (op_reg == DEC_OP_READ) || (op_reg == DEC_OP_READ_INC);
    assign read_go    = mdc_rise && (state_reg == DEC_ST_DEVICE) &&
                        (bit_reg == DEC_ADDR_LAST_BIT) && match_now && op_is_read;
    assign addr_index = addr_reg - DEC_HS_ADDR;
    assign addr_hit   = (addr_reg >= DEC_HS_ADDR) && (addr_reg <= DEC_LN3_ADDR);
    // Unmapped addresses read as zero; clear_w keeps them from clearing anything
    always_comb begin
        unique case (addr_reg)
            DEC_HS_ADDR:  rd_data = count_w[0];
            DEC_LN0_ADDR: rd_data = count_w[1];
            DEC_LN1_ADDR: rd_data = count_w[2];
            DEC_LN2_ADDR: rd_data = count_w[3];
            DEC_LN3_ADDR: rd_data = count_w[4];
            default:      rd_data = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mdc_q_reg <= 1'b0;
        end else begin
            mdc_q_reg <= mdc_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_reg <= DEC_ST_PREAMBLE;
            ones_reg  <= 6'h00;
            bit_reg   <= 4'h0;
            op_reg    <= 2'h0;
            port_reg  <= 5'h00;
            dev_reg   <= 5'h00;
            in_reg    <= 16'h0000;
            match_reg <= 1'b0;
        end else if (mdc_rise) begin
            unique case (state_reg)
                DEC_ST_PREAMBLE: begin
                    if (mdio_i) begin
                        if (ones_reg != DEC_PREAMBLE_BITS) begin
                            ones_reg <= ones_reg + 6'h01;
                        end
                    end else begin
                        ones_reg <= 6'h00;
                        if (ones_reg == DEC_PREAMBLE_BITS) begin
                            state_reg <= DEC_ST_START;
                        end
                    end
                end
                DEC_ST_START: begin
                    bit_reg <= 4'h0;
                    if (!mdio_i) begin
                        state_reg <= DEC_ST_OPCODE;
                    end else begin
                        ones_reg  <= 6'h01;
                        state_reg <= DEC_ST_PREAMBLE;
                    end
                end
                DEC_ST_OPCODE: begin
                    op_reg  <= {op_reg[0], mdio_i};
                    bit_reg <= bit_reg + 4'h1;
                    if (bit_reg == DEC_OP_LAST_BIT) begin
                        bit_reg   <= 4'h0;
                        state_reg <= DEC_ST_PORT;
                    end
                end
                DEC_ST_PORT: begin
                    port_reg <= {port_reg[3:0], mdio_i};
                    bit_reg  <= bit_reg + 4'h1;
                    if (bit_reg == DEC_ADDR_LAST_BIT) begin
                        bit_reg   <= 4'h0;
                        state_reg <= DEC_ST_DEVICE;
                    end
                end
                DEC_ST_DEVICE: begin
                    dev_reg <= {dev_reg[3:0], mdio_i};
                    bit_reg <= bit_reg + 4'h1;
                    if (bit_reg == DEC_ADDR_LAST_BIT) begin
                        bit_reg   <= 4'h0;
                        match_reg <= match_now;
                        state_reg <= DEC_ST_TURN;
                    end
                end
                DEC_ST_TURN: begin
                    bit_reg <= bit_reg + 4'h1;
                    if (bit_reg == DEC_OP_LAST_BIT) begin
                        bit_reg   <= 4'h0;
                        state_reg <= DEC_ST_DATA;
                    end
                end
                DEC_ST_DATA: begin
                    in_reg  <= {in_reg[14:0], mdio_i};
                    bit_reg <= bit_reg + 4'h1;
                    if (bit_reg == DEC_DATA_LAST_BIT) begin
                        bit_reg   <= 4'h0;
                        ones_reg  <= 6'h00;
                        state_reg <= DEC_ST_PREAMBLE;
                    end
                end
                default: begin
                    state_reg <= DEC_ST_PREAMBLE;
                end
            endcase
        end
    end

    // Address frames load the pointer; read-increment advances it after the read
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            addr_reg <= 16'h0000;
        end else if (mdc_rise && state_reg == DEC_ST_DATA &&
                     bit_reg == DEC_DATA_LAST_BIT && match_reg) begin
            if (op_reg == DEC_OP_ADDRESS) begin
                addr_reg <= {in_reg[14:0], mdio_i};
            end else if (op_reg == DEC_OP_READ_INC) begin
                addr_reg <= addr_reg + 16'h0001;
            end
        end
    end

    // Counters are read-only: write frames are accepted and discarded
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            mdio_reg <= 1'b0;
            oe_reg   <= 1'b0;
            out_reg  <= 16'h0000;
        end else if (read_go) begin
            out_reg <= rd_data;
        end else if (mdc_rise && match_reg && op_is_read) begin
            if (state_reg == DEC_ST_TURN && bit_reg == 4'h0) begin
                oe_reg   <= 1'b1;
                mdio_reg <= 1'b0;
            end else if (state_reg == DEC_ST_TURN) begin
                mdio_reg <= out_reg[15];
                out_reg  <= {out_reg[14:0], 1'b0};
            end else if (state_reg == DEC_ST_DATA && bit_reg == DEC_DATA_LAST_BIT) begin
                oe_reg   <= 1'b0;
                mdio_reg <= 1'b0;
            end else if (state_reg == DEC_ST_DATA) begin
                mdio_reg <= out_reg[15];
                out_reg  <= {out_reg[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            kr_clear_reg <= 1'b0;
        end else begin
            kr_clear_reg <= clear_w[0] && kr_mode;
        end
    end

    // Selections only reach the checkers while verification is active
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            hs_sel_reg <= 3'h0;
            ls_sel_reg <= 2'h0;
        end else begin
            if (hs_test_verify_i) begin
                hs_sel_reg <= hs_pattern_sel_i;
            end
            if (ls_test_verify_i) begin
                ls_sel_reg <= ls_pattern_sel_i;
            end
        end
    end

    // The pseudo-random pin outranks test-pattern mode, which outranks decoding
    always_comb begin
        if (pseudo_random_check_pin_i) begin
            event_w[0] = hs_prbs_err_i;
        end else if (hs_test_verify_i) begin
            event_w[0] = hs_pattern_err_i;
        end else begin
            event_w[0] = hs_code_invalid_i | hs_disparity_err_i;
        end
    end

    // Lane 3 shares the lane logic, so it cannot drift from lanes 0 to 2
    genvar g;
    generate
        for (g = 0; g < DEC_LANES; g++) begin : g_lane
            always_comb begin
                if (ls_test_verify_i) begin
                    event_w[g+1] = ls_pattern_err_i[g];
                end else if (mode_i == DEC_MODE_GEN10G) begin
                    event_w[g+1] = ls_align_code_invalid_i[g];
                end else begin
                    event_w[g+1] = ls_code_invalid_i[g] | ls_disparity_err_i[g];
                end
            end
        end
        for (g = 0; g < DEC_COUNTERS; g++) begin : g_count
            logic [15:0] reset_value;
            assign reset_value = (g == 0 && kr_mode) ? DEC_KR_RESET_COUNT
                                                     : DEC_RESET_COUNT;
            assign clear_w[g]  = read_go && addr_hit && (addr_index[2:0] == 3'(g));
            dec_err_counter u_counter (
                .clk_i         (clk_i),
                .reset_n_i     (reset_n_i),
                .reset_value_i (reset_value),
                .count_i       (event_w[g]),
                .clear_i       (clear_w[g]),
                .count_o       (count_w[g])
            );
        end
    endgenerate

    assign mdio_o                  = mdio_reg;
    assign mdio_oe_o               = oe_reg;
    assign kr_fec_clear_o          = kr_clear_reg;
    assign hs_checker_sel_o        = hs_sel_reg;
    assign ls_checker_sel_o        = ls_sel_reg;
    assign fast_side_error_tally_o = count_w[0];
    assign slow_side_lane0_tally_o = count_w[1];
    assign slow_side_lane1_tally_o = count_w[2];
    assign slow_side_lane2_tally_o = count_w[3];
    assign slow_side_lane3_tally_o = count_w[4];
endmodule : dec_error_counters
`default_nettype wire

/* File: sim/dec_error_counters_asserts.sv */
`default_nettype none
module dec_error_counters_chk
    import dec_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  mode_i,
    input wire logic        hs_test_verify_i,
    input wire logic        ls_test_verify_i,
    input wire logic        pseudo_random_check_pin_i,
    input wire logic [2:0]  hs_pattern_sel_i,
    input wire logic        hs_code_invalid_i,
    input wire logic        hs_disparity_err_i,
    input wire logic        hs_pattern_err_i,
    input wire logic        hs_prbs_err_i,
    input wire logic [3:0]  ls_code_invalid_i,
    input wire logic [3:0]  ls_disparity_err_i,
    input wire logic [3:0]  ls_align_code_invalid_i,
    input wire logic [3:0]  ls_pattern_err_i,
    input wire logic [2:0]  hs_checker_sel_o,
    input wire logic        kr_fec_clear_o,
    input wire logic [15:0] fast_side_error_tally_o,
    input wire logic [15:0] slow_side_lane0_tally_o
);
    logic        hs_ev;
    logic        ls_ev;
    logic [15:0] hs;
    logic [15:0] ls;
    assign hs = fast_side_error_tally_o;
    assign ls = slow_side_lane0_tally_o;
    assign hs_ev = pseudo_random_check_pin_i ? hs_prbs_err_i : hs_test_verify_i ?
                   hs_pattern_err_i : hs_code_invalid_i | hs_disparity_err_i;
    assign ls_ev = ls_test_verify_i ? ls_pattern_err_i[0] : mode_i == DEC_MODE_GEN10G ?
                   ls_align_code_invalid_i[0] : ls_code_invalid_i[0] | ls_disparity_err_i[0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Clear cycle may coincide with an event, which then loads one
    sequence fec_pulse;
        kr_fec_clear_o ##1 !kr_fec_clear_o;
    endsequence
    chk_hs_count: assert property (hs_ev && hs != DEC_COUNT_MAX |=>
        hs == $past(hs) + 16'h0001 || hs == 16'h0001)
        else $error("fast tally missed an event");
    chk_hs_hold: assert property (!hs_ev |=>
        hs == $past(hs) || hs == DEC_CLEARED_COUNT)
        else $error("fast tally moved without event");
    chk_hs_saturate: assert property (hs_ev && hs == DEC_COUNT_MAX |=>
        hs == DEC_COUNT_MAX || hs == 16'h0001)
        else $error("fast tally wrapped");
    chk_lane_count: assert property (ls_ev && ls != DEC_COUNT_MAX |=>
        ls == $past(ls) + 16'h0001 || ls == 16'h0001)
        else $error("lane tally missed an event");
    chk_fec_once: assert property (kr_fec_clear_o |-> fec_pulse)
        else $error("fec clear longer than one cycle");
    // The pulse trails the clear by one clock, so the tally is already cleared
    chk_fec_cause: assert property (kr_fec_clear_o |->
        $past(mode_i) == DEC_MODE_KR && hs <= 16'h0001)
        else $error("fec clear without fast read");
    chk_sel_copy: assert property (hs_test_verify_i |=>
        hs_checker_sel_o == $past(hs_pattern_sel_i))
        else $error("pattern select not taken");
    chk_sel_hold: assert property (!hs_test_verify_i |=> $stable(hs_checker_sel_o))
        else $error("pattern select changed");
endmodule : dec_error_counters_chk
bind dec_error_counters dec_error_counters_chk u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
    .hs_test_verify_i(hs_test_verify_i), .ls_test_verify_i(ls_test_verify_i),
    .pseudo_random_check_pin_i(pseudo_random_check_pin_i), .hs_pattern_sel_i(hs_pattern_sel_i),
    .hs_code_invalid_i(hs_code_invalid_i), .hs_disparity_err_i(hs_disparity_err_i),
    .hs_pattern_err_i(hs_pattern_err_i), .hs_prbs_err_i(hs_prbs_err_i),
    .ls_code_invalid_i(ls_code_invalid_i), .ls_disparity_err_i(ls_disparity_err_i),
    .ls_align_code_invalid_i(ls_align_code_invalid_i), .ls_pattern_err_i(ls_pattern_err_i),
    .hs_checker_sel_o(hs_checker_sel_o), .kr_fec_clear_o(kr_fec_clear_o),
    .fast_side_error_tally_o(fast_side_error_tally_o),
    .slow_side_lane0_tally_o(slow_side_lane0_tally_o)
);
`default_nettype wire

/* File: sim/dec_mdio_station.sv */
`default_nettype none
module dec_mdio_station
    import dec_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic mdio_o_i,
    input  wire logic mdio_oe_i,
    output logic      mdc_o,
    output logic      mdio_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic drv_en = 1'b0;
    logic drv_bit = 1'b1;
    // Pull-up: a line nobody drives reads high
    assign mdio_line_o = mdio_oe_i ? mdio_o_i : (drv_en ? drv_bit : 1'b1);
    initial mdc_o = 1'b0;
    // MDC is four system clocks long and stands still between frames
    task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] wd,
                         output logic [15:0] rd);
        logic [63:0] bits;
        bits = {32'hffffffff, 2'b00, op, 5'h05, dev, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            @(negedge clk_i);
            mdc_o = 1'b0;
            drv_en = !op[1] || (i < 46);
            drv_bit = bits[63-i];
            repeat (2) @(negedge clk_i);
            if (i >= 48) rd[63-i] = mdio_line_o;
            mdc_o = 1'b1;
            @(negedge clk_i);
        end
        @(negedge clk_i);
        mdc_o = 1'b0;
        drv_en = 1'b0;
    endtask : frame
endmodule : dec_mdio_station
`default_nettype wire

/* File: sim/decoder_error_counters_test.sv */
`default_nettype none
module decoder_error_counters_test;
    import dec_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [1:0]  mode;
        logic [2:0]  tv;
        logic [3:0]  hs;
        logic [15:0] ls;
        logic        hs_inc;
        logic [3:0]  ls_inc;
    } dec_row_s;
    // tv {pin, fast verify, lane verify}; hs {prbs, pattern, disp, code}
    // ls nibbles {pattern, align, disp, code}
    localparam dec_row_s ROWS [10] = '{
        '{DEC_MODE_KX, 3'b000, 4'b0001, 16'h8421, 1'b1, 4'h3},
        '{DEC_MODE_KX, 3'b000, 4'b0010, 16'h0000, 1'b1, 4'h0},
        '{DEC_MODE_KX, 3'b000, 4'b1100, 16'hf0c0, 1'b0, 4'hc},
        '{DEC_MODE_GEN10G, 3'b000, 4'b0001, 16'h0c53, 1'b1, 4'hc},
        '{DEC_MODE_KR, 3'b000, 4'b0000, 16'h0098, 1'b0, 4'h9},
        '{DEC_MODE_KR, 3'b010, 4'b0101, 16'h0000, 1'b1, 4'h0},
        '{DEC_MODE_KR, 3'b010, 4'b0011, 16'h0000, 1'b0, 4'h0},
        '{DEC_MODE_KR, 3'b001, 4'b0000, 16'ha0f5, 1'b0, 4'ha},
        '{DEC_MODE_KR, 3'b110, 4'b1010, 16'h0000, 1'b1, 4'h0},
        '{DEC_MODE_KR, 3'b100, 4'b0111, 16'h0000, 1'b0, 4'h0}};
    logic        clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic [1:0]  mode = DEC_MODE_KX;
    logic [2:0]  tv = 3'h0;
    logic [3:0]  hs_ev = 4'h0;
    logic [15:0] ls_ev = 16'h0000;
    logic [2:0]  hsel = 3'h0;
    logic [1:0]  lsel = 2'h0;
    logic [4:0]  want_sel;
    logic [2:0]  hsel_q;
    logic [1:0]  lsel_q;
    logic        fec;
    logic        mdc;
    logic        line;
    logic        mdio_o;
    logic        mdio_oe;
    logic [15:0] tally [5];
    logic [15:0] want [5];
    logic [15:0] d;
    int          num_errors = 0;
    int          checks_done = 0;
    int          fec_cnt = 0;
    int          fec_base = 0;
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (fec === 1'b1) fec_cnt++;
    dec_mdio_station stn (.clk_i(clk_i), .mdio_o_i(mdio_o), .mdio_oe_i(mdio_oe),
                          .mdc_o(mdc), .mdio_line_o(line));
    dec_error_counters uut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .mdc_i(mdc), .mdio_i(line),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .phy_addr_i(5'h05), .mode_i(mode),
        .hs_test_verify_i(tv[1]), .ls_test_verify_i(tv[0]), .pseudo_random_check_pin_i(tv[2]),
        .hs_pattern_sel_i(hsel), .ls_pattern_sel_i(lsel), .hs_code_invalid_i(hs_ev[0]),
        .hs_disparity_err_i(hs_ev[1]), .hs_pattern_err_i(hs_ev[2]), .hs_prbs_err_i(hs_ev[3]),
        .ls_code_invalid_i(ls_ev[3:0]), .ls_disparity_err_i(ls_ev[7:4]),
        .ls_align_code_invalid_i(ls_ev[11:8]), .ls_pattern_err_i(ls_ev[15:12]),
        .hs_checker_sel_o(hsel_q), .ls_checker_sel_o(lsel_q), .kr_fec_clear_o(fec),
        .fast_side_error_tally_o(tally[0]), .slow_side_lane0_tally_o(tally[1]),
        .slow_side_lane1_tally_o(tally[2]), .slow_side_lane2_tally_o(tally[3]),
        .slow_side_lane3_tally_o(tally[4]));
    task automatic summarize();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [15:0] got, input logic [15:0] exp_v);
        checks_done++;
        if (got !== exp_v) begin
            num_errors++;
            $display("ERROR t=%0t got=%h want=%h", $time, got, exp_v);
        end
    endtask : check
    task automatic check_all();
        for (int k = 0; k < 5; k++) check(tally[k], want[k]);
    endtask : check_all
    // Address frame first: the read pointer is only loaded by it
    task automatic rd(input logic [15:0] a, input logic [4:0] dev, output logic [15:0] q);
        stn.frame(DEC_OP_ADDRESS, dev, a, q);
        stn.frame(DEC_OP_READ, dev, 16'h0000, q);
    endtask : rd
    task automatic pulse(input logic [3:0] h, input logic [15:0] l, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge clk_i);
            hs_ev = h;
            ls_ev = l;
        end
        @(negedge clk_i);
        hs_ev = 4'h0;
        ls_ev = 16'h0000;
    endtask : pulse
    task automatic do_reset(input logic [1:0] m);
        @(negedge clk_i);
        mode = m;
        tv = 3'h0;
        reset_n_i = 1'b0;
        repeat (3) @(negedge clk_i);
        reset_n_i = 1'b1;
        @(negedge clk_i);
    endtask : do_reset
    initial begin
        repeat (50000) @(posedge clk_i);
        num_errors++;
        summarize();
    end
    initial begin
        do_reset(DEC_MODE_KX);
        want = '{default: DEC_RESET_COUNT};
        check_all();
        pulse(4'h1, 16'h000f, 3);
        want = '{default: DEC_COUNT_MAX};
        check_all();
        for (int k = 0; k < 5; k++) begin
            rd(DEC_HS_ADDR + 16'(k), DEC_DEVAD, d);
            check(d, want[k]);
            want[k] = DEC_CLEARED_COUNT;
            check(tally[k], want[k]);
        end
        check(16'(fec_cnt), 16'h0000);
        pulse(4'h2, 16'h0000, 2);
        want[0] = 16'h0002;
        rd(DEC_HS_ADDR, 5'h01, d);
        check(d, 16'hffff);
        check_all();
        rd(DEC_LN3_ADDR + 16'h0001, DEC_DEVAD, d);
        check(d, 16'h0000);
        check_all();
        want_sel = 5'h00;
        foreach (ROWS[r]) begin
            @(negedge clk_i);
            mode = ROWS[r].mode;
            tv = ROWS[r].tv;
            hsel = 3'(r);
            lsel = 2'(r + 3);
            pulse(ROWS[r].hs, ROWS[r].ls, 1);
            want[0] = want[0] + 16'(ROWS[r].hs_inc);
            for (int k = 0; k < 4; k++) want[k+1] = want[k+1] + 16'(ROWS[r].ls_inc[k]);
            if (tv[1]) want_sel[4:2] = hsel;
            if (tv[0]) want_sel[1:0] = lsel;
            check_all();
            check({11'h000, hsel_q, lsel_q}, {11'h000, want_sel});
        end
        stn.frame(DEC_OP_ADDRESS, DEC_DEVAD, DEC_LN0_ADDR, d);
        stn.frame(DEC_OP_WRITE, DEC_DEVAD, 16'h1234, d);
        check_all();
        for (int k = 1; k < 3; k++) begin
            stn.frame(DEC_OP_READ_INC, DEC_DEVAD, 16'h0000, d);
            check(d, want[k]);
            want[k] = DEC_CLEARED_COUNT;
        end
        check_all();
        do_reset(DEC_MODE_KR);
        check(tally[0], DEC_KR_RESET_COUNT);
        check(tally[1], DEC_RESET_COUNT);
        pulse(4'h1, 16'h0000, 3);
        fec_base = fec_cnt;
        rd(DEC_HS_ADDR, DEC_DEVAD, d);
        check(d, 16'h0003);
        check(16'(fec_cnt - fec_base), 16'h0001);
        summarize();
    end
endmodule : decoder_error_counters_test
`default_nettype wire
